// file: common/uart_port_pkg.sv
// Shared constants and register layouts for the asynchronous serial port
package uart_port_pkg;

    // ==========================================
    // Register addresses
    localparam logic [15:0] ADDR_MODE = 16'hFF70;
    localparam logic [15:0] ADDR_STATUS = 16'hFF71;
    localparam logic [15:0] ADDR_SYNC = 16'hFF72;
    localparam logic [15:0] ADDR_BAUD = 16'hFF73;
    localparam logic [15:0] ADDR_DATA = 16'hFF74;

    // ==========================================
    // Reset and fixed values
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam logic [1:0] MODE_RSVD_ZERO = 2'h0;
    localparam logic [3:0] BAUD_RSVD_ZERO = 4'h0;
    localparam logic [1:0] SYNC_RSVD_ZERO = 2'h0;

    // ==========================================
    // Parity select codes
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // ==========================================
    // Baud source and bit timing
    localparam logic [3:0] SRC_EXT = 4'h8;
    localparam logic [2:0] SRC_INT_MAX = 3'h7;
    localparam logic [3:0] TICK_LAST = 4'hF;
    localparam logic [3:0] TICK_HALF = 4'h7;
    localparam logic [2:0] LAST_BIT_8 = 3'h7;
    localparam logic [2:0] LAST_BIT_7 = 3'h6;

    // ==========================================
    // Register layouts
    typedef struct packed {
        logic tx_enable_bit;
        logic rx_enable_bit;
        logic [1:0] parity_select;
        logic char_length_select;
        logic stop_length_select;
        logic [1:0] rsvd;
    } uart_mode_s;

    typedef struct packed {
        logic [4:0] rsvd;
        logic parity_error_flag;
        logic framing_error_flag;
        logic overrun_error_flag;
    } uart_status_s;

    typedef struct packed {
        logic sync_mode_enable;
        logic slave_select_use;
        logic [1:0] rsvd;
        logic data_phase_select;
        logic first_bit_select;
        logic sync_clock_source;
        logic clock_polarity_select;
    } sync_mode_s;

    typedef struct packed {
        logic [3:0] source_sel;
        logic [3:0] rsvd;
    } baud_sel_s;

endpackage

// file: hdl/uart_baud_gen.sv
// Baud source prescaler: internal power-of-two divider or external pin clock
`timescale 1ns/1ns
module uart_baud_gen #(
    parameter int DIV_W = 8
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Control
    input wire logic [3:0] i_source_sel,
    input wire logic i_ext_baud_clock_pin,
    // Sixteen ticks make one bit time
    output logic o_tick
);

    // ==========================================
    // Elaboration check
    if (DIV_W < 8) begin : g_bad_width
        $error("DIV_W must cover divide by 2^8");
    end

    // ==========================================
    // Prescaler
    logic [DIV_W-1:0] div_cnt_reg;
    logic ext_meta_reg;
    logic ext_sync_reg;
    logic ext_prev_reg;
    logic int_tick;
    logic ext_tick;

    function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] sel);
        div_mask = DIV_W'(8'hFF >> (uart_port_pkg::SRC_INT_MAX - sel));
    endfunction

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Free-running count: a source change mid-frame shifts tick phase
    assign int_tick = (div_cnt_reg & div_mask(i_source_sel[2:0])) ==
                      div_mask(i_source_sel[2:0]);

    // ==========================================
    // External pin clock, synchronised before edge detection
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            ext_meta_reg <= 1'b0;
            ext_sync_reg <= 1'b0;
            ext_prev_reg <= 1'b0;
        end else begin
            ext_meta_reg <= i_ext_baud_clock_pin;
            ext_sync_reg <= ext_meta_reg;
            ext_prev_reg <= ext_sync_reg;
        end
    end

    assign ext_tick = ext_sync_reg & ~ext_prev_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_tick <= 1'b0;
        end else if (i_source_sel == uart_port_pkg::SRC_EXT) begin
            o_tick <= ext_tick;
        end else if (!i_source_sel[3]) begin
            o_tick <= int_tick;
        end else begin
            o_tick <= 1'b0;
        end
    end

endmodule

// file: hdl/uart_port.sv
// Asynchronous serial port: register file, transmitter and receiver
`timescale 1ns/1ns
//
// Functional notes
// - Mode bits 7/6 enable transmit and receive
// - Parity codes none, zero, odd, even
// - Frame: start, 7/8 data, parity, stops
// - Seven-bit mode drops and clears bit 7
// - Receiver checks only one stop bit
// - Odd/even parity mismatch sets status bit 2
// - Missing stop bit sets status bit 1
// - Unread buffer at completion sets bit 0
// - Overrun repeats until buffer is read
// - Reset clears all four registers
// - Source code picks clock divided 2^(n+1)
// - Internal rate is clock/2^(n+1)/16
// - External rate is pin clock/16
// - Sync data phase and first bit fields
// - Sync clock polarity and source fields
// - Transmit and receive run independently
// - External pin clock reaches 31.25 kbps
// - Data write starts frame, done pulse
// - Start bit confirmed at half bit
// - Every frame loads buffer, raises pulse
// - Buffer read clears flags; next frame reloads them
module uart_port (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [15:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Serial pins
    input wire logic i_serial_rx_pin,
    output logic o_serial_tx_pin,
    input wire logic i_ext_baud_clock_pin,
    output logic o_sync_serial_clock_pin,
    // Events
    output logic o_tx_done_irq,
    output logic o_rx_done_irq
);

    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;

    uart_port_pkg::uart_mode_s mode_reg;
    uart_port_pkg::uart_status_s status_reg;
    uart_port_pkg::sync_mode_s sync_reg;
    uart_port_pkg::baud_sel_s baud_reg;
    logic [7:0] rx_buf_reg;
    logic rx_unread_reg;
    logic tick;

    function automatic logic parity_bit(input logic [1:0] sel, input logic [7:0] d);
        case (sel)
            uart_port_pkg::PAR_ODD: parity_bit = ~(^d);
            uart_port_pkg::PAR_EVEN: parity_bit = ^d;
            default: parity_bit = 1'b0;
        endcase
    endfunction

    // ==========================================
    // Baud generator
    uart_baud_gen #(
        .DIV_W(8)
    ) u_baud (
        .i_ref_clk(i_ref_clk),
        .i_rstn(i_rstn),
        .i_source_sel(baud_reg.source_sel),
        .i_ext_baud_clock_pin(i_ext_baud_clock_pin),
        .o_tick(tick)
    );

    // ==========================================
    // Control registers
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            mode_reg <= uart_port_pkg::uart_mode_s'(uart_port_pkg::REG_RESET);
            sync_reg <= uart_port_pkg::sync_mode_s'(uart_port_pkg::REG_RESET);
            baud_reg <= uart_port_pkg::baud_sel_s'(uart_port_pkg::REG_RESET);
        end else if (i_wr) begin
            case (i_addr)
                uart_port_pkg::ADDR_MODE: begin
                    mode_reg <= {i_wdata[7:2], uart_port_pkg::MODE_RSVD_ZERO};
                end
                uart_port_pkg::ADDR_SYNC: begin
                    // Held for the synchronous mode; only the polarity bit is acted on here
                    sync_reg <= {i_wdata[7:6], uart_port_pkg::SYNC_RSVD_ZERO,
                                 i_wdata[3:0]};
                end
                uart_port_pkg::ADDR_BAUD: begin
                    baud_reg <= {i_wdata[7:4], uart_port_pkg::BAUD_RSVD_ZERO};
                end
                default: begin
                end
            endcase
        end
    end

    // Idle level of the sync clock pin is the inverse of the polarity field
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_sync_serial_clock_pin <= 1'b1;
        end else begin
            o_sync_serial_clock_pin <= ~sync_reg.clock_polarity_select;
        end
    end

    // ==========================================
    // Transmitter
    tx_state_e tx_state;
    logic [3:0] tx_cnt_reg;
    logic [2:0] tx_idx_reg;
    logic tx_stop_idx_reg;
    logic [7:0] tx_shift_reg;
    logic tx_par_reg;
    logic tx_bit_end;
    logic tx_finish;
    logic tx_load;
    logic [7:0] tx_data;

    assign tx_bit_end = tick && (tx_cnt_reg == uart_port_pkg::TICK_LAST);
    assign tx_finish = (tx_state == TX_STOP) && tx_bit_end &&
                       (tx_stop_idx_reg == mode_reg.stop_length_select);
    assign tx_load = i_wr && (i_addr == uart_port_pkg::ADDR_DATA) &&
                     mode_reg.tx_enable_bit && (tx_state == TX_IDLE);
    assign tx_data = {i_wdata[7] & mode_reg.char_length_select, i_wdata[6:0]};

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            tx_state <= TX_IDLE;
            tx_cnt_reg <= '0;
            tx_idx_reg <= '0;
            tx_stop_idx_reg <= 1'b0;
            tx_shift_reg <= '0;
            tx_par_reg <= 1'b0;
        end else if (!mode_reg.tx_enable_bit) begin
            tx_state <= TX_IDLE;
        end else begin
            if (tx_state != TX_IDLE && tick) begin
                tx_cnt_reg <= tx_cnt_reg + 1'b1;
            end
            case (tx_state)
                TX_IDLE: begin
                    if (tx_load) begin
                        tx_state <= TX_START;
                        tx_cnt_reg <= '0;
                        tx_shift_reg <= tx_data;
                        tx_par_reg <= parity_bit(mode_reg.parity_select, tx_data);
                    end
                end
                TX_START: begin
                    if (tx_bit_end) begin
                        tx_state <= TX_DATA;
                        tx_idx_reg <= '0;
                    end
                end
                TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
                        tx_idx_reg <= tx_idx_reg + 1'b1;
                        if (tx_idx_reg == (mode_reg.char_length_select ?
                            uart_port_pkg::LAST_BIT_8 : uart_port_pkg::LAST_BIT_7)) begin
                            tx_state <= (mode_reg.parity_select == uart_port_pkg::PAR_NONE) ?
                                        TX_STOP : TX_PARITY;
                            tx_stop_idx_reg <= 1'b0;
                        end
                    end
                end
                TX_PARITY: begin
                    if (tx_bit_end) begin
                        tx_state <= TX_STOP;
                    end
                end
                TX_STOP: begin
                    if (tx_finish) begin
                        tx_state <= TX_IDLE;
                    end else if (tx_bit_end) begin
                        tx_stop_idx_reg <= 1'b1;
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_serial_tx_pin <= 1'b1;
            o_tx_done_irq <= 1'b0;
        end else begin
            case (tx_state)
                TX_START: o_serial_tx_pin <= 1'b0;
                TX_DATA: o_serial_tx_pin <= tx_shift_reg[0];
                TX_PARITY: o_serial_tx_pin <= tx_par_reg;
                default: o_serial_tx_pin <= 1'b1;
            endcase
            o_tx_done_irq <= tx_finish && mode_reg.tx_enable_bit;
        end
    end

    // ==========================================
    // Receiver
    rx_state_e rx_state;
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic [3:0] rx_cnt_reg;
    logic [2:0] rx_idx_reg;
    logic [7:0] rx_shift_reg;
    logic rx_par_reg;
    logic rx_bit_end;
    logic rx_finish;
    logic rx_par_err;
    logic buf_read;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end else begin
            rx_meta_reg <= i_serial_rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    assign rx_bit_end = tick && (rx_cnt_reg == uart_port_pkg::TICK_LAST);
    // Only the first stop bit is sampled; a second one is treated as idle
    assign rx_finish = (rx_state == RX_STOP) && rx_bit_end && mode_reg.rx_enable_bit;
    assign rx_par_err = (mode_reg.parity_select[1]) &&
                        (parity_bit(mode_reg.parity_select, rx_shift_reg) != rx_par_reg);
    assign buf_read = i_rd && (i_addr == uart_port_pkg::ADDR_DATA);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            rx_state <= RX_IDLE;
            rx_cnt_reg <= '0;
            rx_idx_reg <= '0;
            rx_shift_reg <= '0;
            rx_par_reg <= 1'b0;
        end else if (!mode_reg.rx_enable_bit) begin
            rx_state <= RX_IDLE;
        end else begin
            if (rx_state != RX_IDLE && tick) begin
                rx_cnt_reg <= rx_cnt_reg + 1'b1;
            end
            case (rx_state)
                RX_IDLE: begin
                    if (!rx_sync_reg) begin
                        rx_state <= RX_START;
                        rx_cnt_reg <= '0;
                    end
                end
                RX_START: begin
                    if (tick && rx_cnt_reg == uart_port_pkg::TICK_HALF) begin
                        // A glitch shorter than half a bit is dropped
                        rx_state <= rx_sync_reg ? RX_IDLE : RX_DATA;
                        rx_cnt_reg <= '0;
                        rx_idx_reg <= '0;
                        rx_shift_reg <= '0;
                    end
                end
                RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_shift_reg[rx_idx_reg] <= rx_sync_reg;
                        rx_idx_reg <= rx_idx_reg + 1'b1;
                        if (rx_idx_reg == (mode_reg.char_length_select ?
                            uart_port_pkg::LAST_BIT_8 : uart_port_pkg::LAST_BIT_7)) begin
                            rx_state <= (mode_reg.parity_select == uart_port_pkg::PAR_NONE) ?
                                        RX_STOP : RX_PARITY;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_bit_end) begin
                        rx_par_reg <= rx_sync_reg;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_state <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Receive buffer and error status; a completing frame wins over a read
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            status_reg <= uart_port_pkg::uart_status_s'(uart_port_pkg::REG_RESET);
            rx_buf_reg <= '0;
            rx_unread_reg <= 1'b0;
        end else if (rx_finish) begin
            rx_buf_reg <= rx_shift_reg;
            rx_unread_reg <= 1'b1;
            status_reg.parity_error_flag <= rx_par_err;
            status_reg.framing_error_flag <= ~rx_sync_reg;
            status_reg.overrun_error_flag <= rx_unread_reg;
        end else if (buf_read) begin
            rx_unread_reg <= 1'b0;
            status_reg <= uart_port_pkg::uart_status_s'(uart_port_pkg::REG_RESET);
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rx_done_irq <= 1'b0;
        end else begin
            o_rx_done_irq <= rx_finish;
        end
    end

    // ==========================================
    // Read port; status writes fall through and are ignored
    always_ff @(posedge i_ref_clk) begin
        if (!i_rstn) begin
            o_rdata <= uart_port_pkg::READ_ZERO;
        end else if (i_rd) begin
            case (i_addr)
                uart_port_pkg::ADDR_MODE: o_rdata <= mode_reg;
                uart_port_pkg::ADDR_STATUS: o_rdata <= {5'h00, status_reg[2:0]};
                uart_port_pkg::ADDR_SYNC: o_rdata <= sync_reg;
                uart_port_pkg::ADDR_BAUD: o_rdata <= baud_reg;
                uart_port_pkg::ADDR_DATA: o_rdata <= rx_buf_reg;
                default: o_rdata <= uart_port_pkg::READ_ZERO;
            endcase
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rstn);

    a_reset_clears: assert property (disable iff (1'b0) !i_rstn |=>
        (mode_reg == 8'h00 && status_reg == 8'h00 && sync_reg == 8'h00 && baud_reg == 8'h00))
        else $error("registers not cleared by reset");
    a_tx_stop_disable: assert property (!mode_reg.tx_enable_bit |=> tx_state == TX_IDLE)
        else $error("transmitter running while disabled");
    a_rx_stop_disable: assert property (!mode_reg.rx_enable_bit |=> rx_state == RX_IDLE)
        else $error("receiver running while disabled");
    a_tx_start_low: assert property (tx_state == TX_START |=> !o_serial_tx_pin)
        else $error("start bit not low");
    a_rx_seven_bit: assert property (rx_finish && !mode_reg.char_length_select |=>
        !rx_buf_reg[7] && o_rx_done_irq)
        else $error("bit 7 not zero in seven-bit mode");
    a_no_parity_err: assert property (rx_finish && !mode_reg.parity_select[1] |=>
        !status_reg.parity_error_flag)
        else $error("parity error flagged with check off");
    a_framing_flag: assert property (rx_finish |=>
        status_reg.framing_error_flag == !$past(rx_sync_reg))
        else $error("framing flag mismatch");
    a_overrun_flag: assert property (rx_finish |=>
        status_reg.overrun_error_flag == $past(rx_unread_reg))
        else $error("overrun flag mismatch");
    a_read_clears: assert property (buf_read && !rx_finish |=> status_reg == 8'h00)
        else $error("buffer read did not clear flags");
    a_status_upper: assert property (i_rd && i_addr == uart_port_pkg::ADDR_STATUS |=>
        o_rdata[7:3] == 5'h00)
        else $error("status upper bits not zero");
    a_start_confirm: assert property (rx_state == RX_START && rx_sync_reg && tick &&
        rx_cnt_reg == uart_port_pkg::TICK_HALF |=> rx_state == RX_IDLE)
        else $error("false start bit accepted");

    c_rx_frame: cover property (rx_finish);
    c_tx_frame: cover property (tx_finish);
    c_overrun: cover property (rx_finish && rx_unread_reg);
    c_parity_err: cover property (rx_finish && rx_par_err);

endmodule

// file: tb/uart_remote.sv
// Remote serial station that sends and samples frames on the serial lines
`timescale 1ns/1ns
module uart_remote (
    // Clock
    input wire logic i_ref_clk,
    // Serial lines
    input wire logic i_line,
    output logic o_line
);
    initial o_line = 1'b1;
    // ==========================================
    // Last bit is cut short so that a low stop cannot pose as a start
    task automatic send(input int nb, input logic [9:0] bits, input int bclk);
        @(negedge i_ref_clk);
        o_line = 1'b0;
        repeat (bclk) @(negedge i_ref_clk);
        for (int i = 0; i < nb; i++) begin
            o_line = bits[i];
            repeat ((i == nb - 1) ? bclk * 3 / 4 : bclk) @(negedge i_ref_clk);
        end
        o_line = 1'b1;
        repeat (bclk) @(negedge i_ref_clk);
    endtask
    // ==========================================
    // Mid-bit sampling, so a wrong bit time shows as a wrong pattern
    task automatic recv(input int nb, input int bclk, output logic [9:0] got);
        got = 10'h000;
        @(negedge i_line);
        repeat (bclk / 2) @(negedge i_ref_clk);
        for (int i = 0; i < nb; i++) begin
            repeat (bclk) @(negedge i_ref_clk);
            got[i] = i_line;
        end
    endtask
endmodule

// file: tb/uart_port_bench.sv
// Testbench for the asynchronous serial port
`timescale 1ns/1ns
module uart_port_bench;
    logic i_ref_clk = 0;
    logic i_rstn = 0;
    logic i_wr = 0;
    logic i_rd = 0;
    logic ext = 0;
    logic [15:0] i_addr = 16'h0000;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata, rv;
    logic o_serial_tx_pin, o_sync_serial_clock_pin, o_tx_done_irq, o_rx_done_irq, line;
    logic [9:0] got;
    int fails = 0;
    int compares = 0;
    uart_port i_dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_serial_rx_pin(line), .o_serial_tx_pin(o_serial_tx_pin),
        .i_ext_baud_clock_pin(ext), .o_sync_serial_clock_pin(o_sync_serial_clock_pin),
        .o_tx_done_irq(o_tx_done_irq), .o_rx_done_irq(o_rx_done_irq));
    uart_remote i_remote (.i_ref_clk(i_ref_clk), .i_line(o_serial_tx_pin), .o_line(line));
    initial begin
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    // External baud pin: one rising edge every 4 clocks gives 64 clocks a bit
    always #20 ext = ~ext;
    // ==========================================
    // Shared tasks
    task automatic check(input logic [9:0] seen, input logic [9:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge i_ref_clk);
        i_addr = a;
        i_wdata = d;
        i_wr = 1;
        @(negedge i_ref_clk);
        i_wr = 0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge i_ref_clk);
        i_addr = a;
        i_rd = 1;
        @(negedge i_ref_clk);
        i_rd = 0;
        @(negedge i_ref_clk);
        d = o_rdata;
    endtask
    task automatic wait_irq(input bit tx);
        int n;
        n = 0;
        while (n < 3000 && ((tx ? o_tx_done_irq : o_rx_done_irq) !== 1'b1)) begin
            @(posedge i_ref_clk);
            #1;
            n++;
        end
        check(10'(n < 3000), 10'h001);
    endtask
    task automatic tx_case(input logic [7:0] mode, input logic [7:0] d, input int bclk);
        logic [9:0] exp;
        logic [7:0] dd;
        int nb;
        time t0;
        wr(uart_port_pkg::ADDR_MODE, mode);
        dd = mode[3] ? d : {1'b0, d[6:0]};
        nb = mode[3] ? 8 : 7;
        exp = {2'b00, dd};
        if (mode[5:4] != uart_port_pkg::PAR_NONE) begin
            exp[nb] = (mode[5:4] == uart_port_pkg::PAR_ODD) ? ~^dd :
                      (mode[5:4] == uart_port_pkg::PAR_EVEN) ? ^dd : 1'b0;
            nb++;
        end
        exp[nb] = 1'b1;
        fork
            i_remote.recv(nb + 1, bclk, got);
            wr(uart_port_pkg::ADDR_DATA, d);
        join
        check(got, exp);
        t0 = $time;
        wait_irq(1);
        check(10'(($time - t0) > bclk * 10), 10'(mode[2]));
    endtask
    task automatic rx_case(input logic [7:0] mode, input logic [9:0] bits, input int nb,
                           input bit rdbuf, input logic [7:0] ed, input logic [7:0] es);
        wr(uart_port_pkg::ADDR_MODE, mode);
        fork
            i_remote.send(nb, bits, 32);
            wait_irq(0);
            begin
                wr(uart_port_pkg::ADDR_DATA, 8'hFF);
                wait_irq(1);
            end
        join
        rd(uart_port_pkg::ADDR_STATUS, rv);
        check(10'(rv), 10'(es));
        if (rdbuf) begin
            rd(uart_port_pkg::ADDR_DATA, rv);
            check(10'(rv), 10'(ed));
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #500000;
        fails++;
        end_of_test();
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (6) @(negedge i_ref_clk);
        i_rstn = 1;
        for (int k = 0; k < 6; k++) begin
            rd(uart_port_pkg::ADDR_MODE + 16'(k), rv);
            check(10'(rv), 10'h000);
        end
        check(10'(o_sync_serial_clock_pin), 10'h001);
        wr(uart_port_pkg::ADDR_STATUS, 8'hFF);
        rd(uart_port_pkg::ADDR_STATUS, rv);
        check(10'(rv), 10'h000);
        wr(uart_port_pkg::ADDR_SYNC, 8'hFF);
        rd(uart_port_pkg::ADDR_SYNC, rv);
        check(10'(rv), 10'h0CF);
        check(10'(o_sync_serial_clock_pin), 10'h000);
        wr(uart_port_pkg::ADDR_SYNC, 8'h00);
        wr(uart_port_pkg::ADDR_MODE, 8'hFF);
        rd(uart_port_pkg::ADDR_MODE, rv);
        check(10'(rv), 10'h0FC);
        wr(uart_port_pkg::ADDR_BAUD, 8'h0F);
        rd(uart_port_pkg::ADDR_BAUD, rv);
        check(10'(rv), 10'h000);
        for (int p = 0; p < 4; p++) begin
            tx_case(8'hC8 | 8'(p << 4), 8'hA5 ^ 8'(p), 32);
        end
        tx_case(8'hE4, 8'hD3, 32);
        // Baud source changes only while both directions are idle
        wr(uart_port_pkg::ADDR_BAUD, 8'h10);
        tx_case(8'hC8, 8'h96, 64);
        wr(uart_port_pkg::ADDR_BAUD, 8'h20);
        tx_case(8'hCC, 8'h69, 128);
        wr(uart_port_pkg::ADDR_BAUD, 8'h80);
        tx_case(8'hC8, 8'h3C, 64);
        wr(uart_port_pkg::ADDR_BAUD, 8'h00);
        rx_case(8'hF8, 10'h25A, 10, 1, 8'h5A, 8'h00);
        rx_case(8'hFC, 10'h35A, 10, 1, 8'h5A, 8'h04);
        rx_case(8'hF8, 10'h05A, 10, 1, 8'h5A, 8'h02);
        rx_case(8'hC0, 10'h0D5, 8, 1, 8'h55, 8'h00);
        rx_case(8'hF8, 10'h211, 10, 0, 8'h00, 8'h00);
        rx_case(8'hF8, 10'h222, 10, 0, 8'h00, 8'h01);
        rx_case(8'hF8, 10'h233, 10, 1, 8'h33, 8'h01);
        rd(uart_port_pkg::ADDR_STATUS, rv);
        check(10'(rv), 10'h000);
        end_of_test();
    end
endmodule
